// >>> tape_front_panel_control.v
// Front-panel control, lamps and interrupt logic of a tape subsystem.
// Assumes all inputs are synchronous to I_CORE_CLK; button inputs are one-cycle press pulses.
//
// The register offsets and strobed register access are this design's own decisions.
`timescale 1ns/1ps
`include "tape_panel_regs.vh"

module tape_front_panel_control (
    input  wire        I_CORE_CLK,
    input  wire        I_RESET_N,
    input  wire [7:0]  I_ADDR,
    input  wire [15:0] I_WDATA,
    input  wire        I_WR,
    input  wire        I_RD,
    output reg  [15:0] O_RDATA,
    input  wire        I_LOAD_REWIND_UNLOAD_BUTTON,
    input  wire        I_ONLINE_TOGGLE,
    input  wire        I_TAPE_THREADED,
    input  wire        I_BEGINNING_OF_TAPE,
    input  wire        I_END_OF_TAPE,
    input  wire        I_POWERED_MOTION,
    input  wire        I_REEL_MOUNTED,
    input  wire        I_RING_PRESENT,
    input  wire        I_IDENTIFICATION_BURST_SEEN,
    input  wire        I_IDENTIFICATION_BURST_VALID,
    input  wire        I_FORMATTER_RUNNING,
    input  wire        I_FORMATTER_ERROR,
    input  wire        I_MOTION_DONE,
    input  wire        I_IDLE,
    input  wire        I_DIAG_REQUEST,
    input  wire        I_STRAP_ENABLE,
    input  wire [2:0]  I_STRAP_LEVEL,
    input  wire [8:0]  I_STRAP_VECTOR,
    output reg         O_LOAD_CMD,
    output reg         O_REWIND_CMD,
    output reg         O_UNLOAD_CMD,
    output reg         O_LOAD_LAMP,
    output reg         O_ONLINE_LAMP,
    output reg         O_FORMATTER_HEALTHY_LAMP,
    output reg         O_VOLUME_CHECK_LAMP,
    output reg         O_DENSITY_ERROR_LAMP,
    output reg         O_WRITE_LOCK_LAMP,
    output reg         O_BOT_LAMP,
    output reg         O_EOT_LAMP,
    output reg         O_SELFTEST_RUN,
    output reg         O_DIAG_RUN,
    output reg         O_IRQ,
    output reg  [2:0]  O_IRQ_LEVEL,
    output reg  [8:0]  O_IRQ_VECTOR
);

    // ==========================================================
    // Internal state
    reg                    strap_taken;
    reg                    irq_enable;
    reg [`ST_WIDTH-1:0]    status;
    reg [`ST_WIDTH-1:0]    mask;
    reg                    error_prev;

    wire                   wr_ctrl;
    wire                   rd_status;
    wire                   host_rewind;
    wire                   host_unload;
    wire                   panel_press;
    wire                   do_load;
    wire                   do_rewind;
    wire                   do_unload;
    wire                   fail_event;
    wire [`ST_WIDTH-1:0]   next_events;
    wire [`ST_WIDTH-1:0]   next_status;

    assign wr_ctrl   = I_WR && (I_ADDR == `ADDR_CTRL);
    assign rd_status = I_RD && (I_ADDR == `ADDR_STATUS);

    // ==========================================================
    // Transport actions

    assign host_rewind = wr_ctrl && I_WDATA[`CTRL_REWIND] && O_ONLINE_LAMP;
    assign host_unload = wr_ctrl && I_WDATA[`CTRL_UNLOAD] && O_ONLINE_LAMP;
    assign panel_press = I_LOAD_REWIND_UNLOAD_BUTTON;

    assign do_load   = panel_press && !O_LOAD_LAMP && I_TAPE_THREADED;
    assign do_rewind = O_LOAD_LAMP && !I_BEGINNING_OF_TAPE
                       && ((panel_press && !O_ONLINE_LAMP) || host_rewind);
    assign do_unload = O_LOAD_LAMP && I_BEGINNING_OF_TAPE
                       && ((panel_press && !O_ONLINE_LAMP) || host_unload);

    assign fail_event = O_ONLINE_LAMP && I_FORMATTER_ERROR && !error_prev;

    assign next_events[`ST_SPECIAL] = fail_event;
    assign next_events[`ST_READY]   = I_MOTION_DONE;
    assign next_events[`ST_VOLCHG]  = I_ONLINE_TOGGLE;

    // Reading clears, a new event in the same cycle survives.
    assign next_status = (rd_status ? {`ST_WIDTH{1'b0}} : status) | next_events;

    // ==========================================================
    // Panel and transport state
    always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_LOAD_CMD               <= 1'b0;
            O_REWIND_CMD             <= 1'b0;
            O_UNLOAD_CMD             <= 1'b0;
            O_LOAD_LAMP              <= 1'b0;
            O_ONLINE_LAMP            <= 1'b0;
            O_FORMATTER_HEALTHY_LAMP <= 1'b0;
            O_VOLUME_CHECK_LAMP      <= 1'b0;
            O_DENSITY_ERROR_LAMP     <= 1'b0;
            O_WRITE_LOCK_LAMP        <= 1'b1;
            O_BOT_LAMP               <= 1'b0;
            O_EOT_LAMP               <= 1'b0;
            O_SELFTEST_RUN           <= 1'b0;
            O_DIAG_RUN               <= 1'b0;
            error_prev               <= 1'b0;
        end else begin
            O_LOAD_CMD   <= do_load;
            O_REWIND_CMD <= do_rewind;
            O_UNLOAD_CMD <= do_unload;
            if (do_load) begin
                O_LOAD_LAMP <= 1'b1;
            end else if (do_unload) begin
                O_LOAD_LAMP <= 1'b0;
            end
            if (I_ONLINE_TOGGLE) begin
                O_ONLINE_LAMP <= !O_ONLINE_LAMP;
            end
            if (I_ONLINE_TOGGLE) begin
                O_VOLUME_CHECK_LAMP <= 1'b1;
            end else if (wr_ctrl) begin
                O_VOLUME_CHECK_LAMP <= 1'b0;
            end
            O_FORMATTER_HEALTHY_LAMP <= I_FORMATTER_RUNNING && !I_FORMATTER_ERROR;
            if (I_IDENTIFICATION_BURST_SEEN && I_BEGINNING_OF_TAPE) begin
                O_DENSITY_ERROR_LAMP <= !I_IDENTIFICATION_BURST_VALID;
            end else if (do_unload) begin
                O_DENSITY_ERROR_LAMP <= 1'b0;
            end
            O_WRITE_LOCK_LAMP <= !I_REEL_MOUNTED || !I_RING_PRESENT;
            O_BOT_LAMP <= I_BEGINNING_OF_TAPE;
            if (I_END_OF_TAPE && I_POWERED_MOTION) begin
                O_EOT_LAMP <= 1'b1;
            end else if (I_BEGINNING_OF_TAPE || do_unload) begin
                O_EOT_LAMP <= 1'b0;
            end
            O_SELFTEST_RUN <= I_IDLE;
            O_DIAG_RUN <= I_DIAG_REQUEST && !O_ONLINE_LAMP && !I_ONLINE_TOGGLE;
            error_prev <= I_FORMATTER_ERROR;
        end
    end

    // ==========================================================
    // Interrupt level and vector
    always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            strap_taken  <= 1'b0;
            O_IRQ_LEVEL  <= `IRQ_LEVEL_RST;
            O_IRQ_VECTOR <= `IRQ_VECTOR_RST;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            if (I_STRAP_ENABLE) begin
                O_IRQ_LEVEL  <= I_STRAP_LEVEL;
                O_IRQ_VECTOR <= I_STRAP_VECTOR;
            end
        end
    end

    // ==========================================================
    // Register port and interrupt
    always @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            irq_enable <= 1'b0;
            status     <= {`ST_WIDTH{1'b0}};
            mask       <= `MASK_RST;
            O_IRQ      <= 1'b0;
            O_RDATA    <= 16'h0000;
        end else begin
            if (wr_ctrl) begin
                irq_enable <= I_WDATA[`CTRL_IE];
            end
            if (I_WR && (I_ADDR == `ADDR_MASK)) begin
                mask <= I_WDATA[`ST_WIDTH-1:0];
            end
            status <= next_status;
            O_IRQ <= irq_enable && (|(next_status & mask));
            O_RDATA <= 16'h0000;
            if (I_RD) begin
                case (I_ADDR)
                    `ADDR_CTRL: begin
                        O_RDATA <= {15'h0000, irq_enable};
                    end
                    `ADDR_STATUS: begin
                        O_RDATA <= {13'h0000, status};
                    end
                    `ADDR_MASK: begin
                        O_RDATA <= {13'h0000, mask};
                    end
                    `ADDR_PANEL: begin
                        O_RDATA <= {6'h00, O_DIAG_RUN, O_SELFTEST_RUN, O_EOT_LAMP,
                                    O_BOT_LAMP, O_WRITE_LOCK_LAMP, O_DENSITY_ERROR_LAMP,
                                    O_VOLUME_CHECK_LAMP, O_FORMATTER_HEALTHY_LAMP,
                                    O_ONLINE_LAMP, O_LOAD_LAMP};
                    end
                    `ADDR_IRQINFO: begin
                        O_RDATA <= {4'h0, O_IRQ_LEVEL, O_IRQ_VECTOR};
                    end
                    default: begin
                        O_RDATA <= 16'h0000;
                    end
                endcase
            end
        end
    end

endmodule // tape_front_panel_control

// >>> tape_panel_regs.vh
// Constants for the tape front-panel control block.
// Assumes a single 125 MHz core clock and a plain register port.
//
// Functional notes
// - Interrupt level 5 and vector 224 by default, strap inputs may replace them.
// - Button press on threaded unloaded tape loads it and lights the button lamp.
// - Button press on loaded tape away from beginning rewinds it to beginning.
// - Button press with tape at beginning unloads the tape.
// - Button rewind and unload are ignored while on-line.
// - On-line button toggles on-line state and its lamp.
// - On-line means host-only rewind and unload, panel load still works; panel diagnostics only off-line.
// - Formatter-health lamp lit only while formatter runs without error.
// - Volume-check lamp set when on-line state changes since last host command.
// - Density-error lamp lit on invalid identification burst; reading still allowed.
// - Write-lock lamp lit with no reel or no file-protect ring.
// - Beginning-of-tape lamp follows the beginning marker exactly.
// - End-of-tape lamp set only by powered motion past the end marker.
// - Self-test runs while the subsystem is idle.
// - Formatter failure while on-line is reported to the host.
// - Enabled interrupt on special-condition, ready or volume-change status bit.
`ifndef TAPE_PANEL_REGS_VH
`define TAPE_PANEL_REGS_VH

// ==========================================================
// Register byte addresses
`define ADDR_CTRL      8'h00
`define ADDR_STATUS    8'h04
`define ADDR_MASK      8'h08
`define ADDR_PANEL     8'h0C
`define ADDR_IRQINFO   8'h10

// ==========================================================
// Control register fields
`define CTRL_IE        0
`define CTRL_REWIND    1
`define CTRL_UNLOAD    2

// ==========================================================
// Status and mask fields
`define ST_SPECIAL     0
`define ST_READY       1
`define ST_VOLCHG      2
`define ST_WIDTH       3

// ==========================================================
// Reset values
`define IRQ_LEVEL_RST  3'h5
`define IRQ_VECTOR_RST 9'h0E0
`define MASK_RST       3'h0

`endif

// >>> tape_transport_model.sv
// Behavioural tape transport for the front-panel testbench.
// Assumes one clock shared with the block and command pulses one cycle long.
`timescale 1ns/1ps
module tape_transport_model (
    input  wire i_clk,
    input  wire i_rst_n,
    input  wire i_load,
    input  wire i_rewind,
    input  wire i_unload,
    input  wire i_thread,
    input  wire i_move,
    output reg  o_bot,
    output reg  o_threaded,
    output reg  o_done
);
    reg [2:0] count;
    // ==========================================================
    // Motion: load and unload finish at once, rewind takes a few cycles.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            {o_bot, o_threaded, o_done, count} <= 6'h00;
        end else begin
            o_done <= i_load | i_unload | (count == 3'h1);
            count <= i_rewind ? 3'h4 : ((count != 3'h0) ? count - 3'h1 : 3'h0);
            o_threaded <= (o_threaded | i_thread) & ~i_unload;
            if (i_load | (count == 3'h1)) begin
                o_bot <= 1'b1;
            end else if (i_move | i_unload) begin
                o_bot <= 1'b0;
            end
        end
    end
endmodule // tape_transport_model

// >>> tape_front_panel_control_properties.sv
// Checker of the front-panel block's port behaviour.
// Assumes it is bound to the block and sees only its ports.
`timescale 1ns/1ps
module tape_panel_checker (
    input wire        I_CORE_CLK, I_RESET_N, I_RD, I_WR, I_STRAP_ENABLE,
    input wire        I_LOAD_REWIND_UNLOAD_BUTTON, I_ONLINE_TOGGLE, I_BEGINNING_OF_TAPE,
    input wire        I_END_OF_TAPE, I_POWERED_MOTION, I_REEL_MOUNTED, I_RING_PRESENT,
    input wire        I_FORMATTER_RUNNING, I_FORMATTER_ERROR, O_REWIND_CMD, O_UNLOAD_CMD,
    input wire        O_ONLINE_LAMP, O_VOLUME_CHECK_LAMP, O_FORMATTER_HEALTHY_LAMP,
    input wire        O_WRITE_LOCK_LAMP, O_BOT_LAMP, O_EOT_LAMP,
    input wire [15:0] O_RDATA,
    input wire [2:0]  O_IRQ_LEVEL,
    input wire [8:0]  O_IRQ_VECTOR
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    // ==========================================================
    // Assertions.
    a_irq_defaults: assert property (!I_STRAP_ENABLE |->
        O_IRQ_LEVEL == 3'h5 && O_IRQ_VECTOR == 9'h0E0) else $error("irq default wrong");
    a_online_refuse: assert property (I_LOAD_REWIND_UNLOAD_BUTTON && O_ONLINE_LAMP
        && !I_WR |=> !O_REWIND_CMD && !O_UNLOAD_CMD) else $error("button acted on-line");
    a_online_flip: assert property (I_ONLINE_TOGGLE |=>
        O_ONLINE_LAMP != $past(O_ONLINE_LAMP) && O_VOLUME_CHECK_LAMP) else $error("toggle");
    a_healthy_lamp: assert property (1'b1 |=> O_FORMATTER_HEALTHY_LAMP ==
        $past(I_FORMATTER_RUNNING && !I_FORMATTER_ERROR)) else $error("healthy lamp");
    a_write_lock: assert property (1'b1 |=> O_WRITE_LOCK_LAMP ==
        $past(!I_REEL_MOUNTED || !I_RING_PRESENT)) else $error("write lock lamp");
    a_bot_follow: assert property (1'b1 |=> O_BOT_LAMP ==
        $past(I_BEGINNING_OF_TAPE)) else $error("bot lamp");
    a_eot_powered: assert property ($rose(O_EOT_LAMP) |->
        $past(I_END_OF_TAPE && I_POWERED_MOTION)) else $error("eot lamp without motion");
    a_rdata_quiet: assert property (!I_RD |=> O_RDATA == 16'h0000)
        else $error("read data outside read");
endmodule // tape_panel_checker

bind tape_front_panel_control tape_panel_checker u_tape_panel_checker (.*);

// >>> tape_front_panel_control_tb_top.sv
// Self-checking testbench of the tape front-panel block.
// Assumes the transport model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "tape_panel_regs.vh"
module tape_front_panel_control_tb_top;
    reg I_CORE_CLK, I_RESET_N, I_WR, I_RD, I_LOAD_REWIND_UNLOAD_BUTTON, I_ONLINE_TOGGLE;
    reg I_END_OF_TAPE, I_POWERED_MOTION, I_REEL_MOUNTED, I_RING_PRESENT, I_IDLE;
    reg I_IDENTIFICATION_BURST_SEEN, I_IDENTIFICATION_BURST_VALID, I_DIAG_REQUEST;
    reg I_FORMATTER_RUNNING, I_FORMATTER_ERROR, I_STRAP_ENABLE, thread, move;
    reg [7:0] I_ADDR;
    reg [15:0] I_WDATA;
    reg [2:0] I_STRAP_LEVEL;
    reg [8:0] I_STRAP_VECTOR;
    wire I_TAPE_THREADED, I_BEGINNING_OF_TAPE, I_MOTION_DONE, O_LOAD_CMD, O_REWIND_CMD;
    wire O_UNLOAD_CMD, O_LOAD_LAMP, O_ONLINE_LAMP, O_FORMATTER_HEALTHY_LAMP, O_IRQ;
    wire O_VOLUME_CHECK_LAMP, O_DENSITY_ERROR_LAMP, O_WRITE_LOCK_LAMP, O_BOT_LAMP;
    wire O_EOT_LAMP, O_SELFTEST_RUN, O_DIAG_RUN;
    wire [15:0] O_RDATA;
    wire [2:0] O_IRQ_LEVEL;
    wire [8:0] O_IRQ_VECTOR;
    integer errors = 0, checked = 0, cycles = 0, i;
    tape_front_panel_control u_tape_front_panel_control (.*);
    tape_transport_model u_tape_transport_model (.i_clk(I_CORE_CLK), .i_rst_n(I_RESET_N),
        .i_load(O_LOAD_CMD), .i_rewind(O_REWIND_CMD), .i_unload(O_UNLOAD_CMD),
        .i_thread(thread), .i_move(move), .o_bot(I_BEGINNING_OF_TAPE),
        .o_threaded(I_TAPE_THREADED), .o_done(I_MOTION_DONE));
    // ==========================================================
    // Tasks.
    task print_verdict;
        begin
            if (errors == 0 && checked > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    task chk(input string name, input [15:0] got, input [15:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("Error %0s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [15:0] d);
        begin
            @(posedge I_CORE_CLK) {I_ADDR, I_WDATA, I_WR} <= {a, d, 1'b1};
            @(posedge I_CORE_CLK) I_WR <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, input [15:0] exp, input string name);
        begin
            @(posedge I_CORE_CLK) {I_ADDR, I_RD} <= {a, 1'b1};
            @(posedge I_CORE_CLK) I_RD <= 1'b0;
            @(negedge I_CORE_CLK) chk(name, O_RDATA, exp);
        end
    endtask
    task pulse(input [3:0] w);
        begin
            @(posedge I_CORE_CLK)
                {I_LOAD_REWIND_UNLOAD_BUTTON, I_ONLINE_TOGGLE, move, I_IDENTIFICATION_BURST_SEEN} <= w;
            @(posedge I_CORE_CLK)
                {I_LOAD_REWIND_UNLOAD_BUTTON, I_ONLINE_TOGGLE, move, I_IDENTIFICATION_BURST_SEEN} <= 4'h0;
            @(negedge I_CORE_CLK);
        end
    endtask
    // ==========================================================
    // Clock, timeout and main sequence.
    initial begin
        I_CORE_CLK = 0;
        forever #4 I_CORE_CLK = ~I_CORE_CLK;
    end
    always @(posedge I_CORE_CLK) begin
        cycles = cycles + 1;
        if (cycles == 3000) begin
            errors = errors + 1;
            print_verdict;
        end
    end
    initial begin
        {I_RESET_N, I_WR, I_RD, I_LOAD_REWIND_UNLOAD_BUTTON, I_ONLINE_TOGGLE, I_END_OF_TAPE} = 0;
        {I_POWERED_MOTION, I_IDLE, I_IDENTIFICATION_BURST_SEEN, I_IDENTIFICATION_BURST_VALID} = 0;
        {I_DIAG_REQUEST, I_FORMATTER_ERROR, I_STRAP_ENABLE, thread, move, I_ADDR, I_WDATA} = 0;
        {I_REEL_MOUNTED, I_RING_PRESENT, I_FORMATTER_RUNNING, I_STRAP_LEVEL} = 6'h3A;
        I_STRAP_VECTOR = 9'h055;
        repeat (4) @(posedge I_CORE_CLK);
        {I_RESET_N, thread} <= 2'b11;
        rd(`ADDR_IRQINFO, 16'h0AE0, "irqinfo");
        pulse(4'h8);
        chk("load", {O_LOAD_CMD, O_LOAD_LAMP}, 16'h0003);
        repeat (3) @(posedge I_CORE_CLK);
        pulse(4'h1);
        chk("density bot", {O_DENSITY_ERROR_LAMP, O_BOT_LAMP}, 16'h0003);
        pulse(4'h2);
        pulse(4'h4);
        chk("online", {O_ONLINE_LAMP, O_VOLUME_CHECK_LAMP}, 16'h0003);
        pulse(4'h8);
        chk("refused", {O_REWIND_CMD, O_UNLOAD_CMD}, 16'h0000);
        @(posedge I_CORE_CLK) I_FORMATTER_ERROR <= 1'b1;
        rd(`ADDR_STATUS, 16'h0007, "status");
        chk("healthy", O_FORMATTER_HEALTHY_LAMP, 16'h0000);
        @(posedge I_CORE_CLK) I_FORMATTER_ERROR <= 1'b0;
        wr(`ADDR_MASK, 16'h0002);
        wr(`ADDR_CTRL, 16'h0001);
        @(negedge I_CORE_CLK) chk("volcheck", O_VOLUME_CHECK_LAMP, 16'h0000);
        pulse(4'h4);
        pulse(4'h8);
        chk("rewind", {O_REWIND_CMD, O_IRQ}, 16'h0002);
        for (i = 0; i < 20 && O_BOT_LAMP !== 1'b1; i = i + 1) @(posedge I_CORE_CLK);
        @(negedge I_CORE_CLK) chk("bot irq", {O_BOT_LAMP, O_IRQ}, 16'h0003);
        rd(`ADDR_STATUS, 16'h0006, "status");
        chk("irq", O_IRQ, 16'h0000);
        pulse(4'h8);
        chk("unload", {O_UNLOAD_CMD, O_LOAD_LAMP}, 16'h0002);
        @(posedge I_CORE_CLK) I_END_OF_TAPE <= 1'b1;
        repeat (2) @(negedge I_CORE_CLK);
        chk("eot by hand", O_EOT_LAMP, 16'h0000);
        @(posedge I_CORE_CLK) I_POWERED_MOTION <= 1'b1;
        repeat (2) @(negedge I_CORE_CLK);
        chk("eot", O_EOT_LAMP, 16'h0001);
        @(posedge I_CORE_CLK) {I_IDLE, I_DIAG_REQUEST, I_RING_PRESENT} <= 3'b110;
        repeat (2) @(negedge I_CORE_CLK);
        chk("idle", {O_SELFTEST_RUN, O_DIAG_RUN, O_WRITE_LOCK_LAMP}, 16'h0007);
        rd(8'hFC, 16'h0000, "unmapped");
        print_verdict;
    end
endmodule // tape_front_panel_control_tb_top
